//--- frd_defines.svh
// Offsets, field positions, reset values and counts of the divider block.
`ifndef FRD_DEFINES_SVH
`define FRD_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FRD_ADDR_DIVIDER 4'h4
`define FRD_ADDR_GAIN 4'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define FRD_SEL_BIT 7
`define FRD_GAIN_SEL_HI 7
`define FRD_GAIN_SEL_LO 6
`define FRD_GAIN_SEL_ADC 2'h0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define FRD_M_RST 7'h10
`define FRD_N_RST 4'h6
`define FRD_P_RST 3'h0
`define FRD_SEL_RST 1'h0
`define FRD_ADC_GAIN_RST 6'h2A
`define FRD_ADC_MUTE_CODE 6'h3F
`define FRD_ZERO_DB_CODE 7'h2A
`define FRD_M_ZERO_FACTOR 8'h80
`define FRD_N_ZERO_FACTOR 5'h10
`define FRD_P_ZERO_FACTOR 4'h8

// ****************************************************************
// Timing counts
// ****************************************************************
`define FRD_FS_PRESCALE_SHIFT 4

`endif

//--- frd_pkg.sv
// Types shared by the divider and gain register block.
package frd_pkg;

	// Raw divider fields as written by software.
	typedef struct packed {
		logic [6:0] m;
		logic [3:0] n;
		logic [2:0] p;
	} frd_div_type;

	// Decoded ADC gain setting.
	typedef struct packed {
		logic [5:0] code;
		logic mute;
		logic signed [6:0] db;
	} frd_adc_gain_type;

	// Deferred apply sequence, Gray coded from IDLE to WAIT2; the return to IDLE flips both bits.
	typedef enum logic [1:0] {
		FRD_APPLY_IDLE = 2'b00,
		FRD_APPLY_WAIT1 = 2'b01,
		FRD_APPLY_WAIT2 = 2'b11
	} frd_apply_state_type;

endpackage : frd_pkg

//--- frd_regs.sv
// Frame rate divider and ADC gain registers with frame sync generation.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "frd_defines.svh"
`default_nettype none

module frd_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Serial port mode
	input wire logic fast_bclk_en,
	input wire logic serial_master,
	output logic bit_clock_tick,
	// Frame timing
	output logic frame_sync_rate,
	output logic coarse_mode,
	output logic divider_write_select,
	output frd_pkg::frd_div_type div_active,
	// ADC gain
	output frd_pkg::frd_adc_gain_type adc_gain,
	// Other gain subregisters held elsewhere
	output logic gain_sub_wr,
	output logic [7:0] gain_sub_wdata,
	input wire logic [7:0] dac_gain_in,
	input wire logic [7:0] sidetone_in,
	input wire logic [7:0] sub4_in
);
	import frd_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	frd_div_type div_staged_ff;
	frd_div_type nxt_div_staged;
	frd_div_type div_active_ff;
	frd_div_type nxt_div_active;
	logic divider_write_select_ff;
	logic nxt_divider_write_select;
	logic coarse_mode_ff;
	logic nxt_coarse_mode;
	frd_apply_state_type apply_state_ff;
	frd_apply_state_type nxt_apply_state;
	frd_adc_gain_type adc_gain_ff;
	frd_adc_gain_type nxt_adc_gain;
	logic div_rd_ptr_ff;
	logic nxt_div_rd_ptr;
	logic [1:0] gain_rd_ptr_ff;
	logic [1:0] nxt_gain_rd_ptr;
	logic [7:0] reg_rdata_ff;
	logic [7:0] nxt_reg_rdata;
	logic [20:0] fs_cnt_ff;
	logic [20:0] nxt_fs_cnt;
	logic frame_sync_ff;
	logic nxt_frame_sync;
	logic [3:0] bclk_cnt_ff;
	logic [3:0] nxt_bclk_cnt;
	logic bit_clock_tick_ff;
	logic nxt_bit_clock_tick;
	logic gain_sub_wr_ff;
	logic nxt_gain_sub_wr;
	logic [7:0] gain_sub_wdata_ff;
	logic [7:0] nxt_gain_sub_wdata;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire hit_div = (reg_addr == `FRD_ADDR_DIVIDER);
	wire hit_gain = (reg_addr == `FRD_ADDR_GAIN);
	wire wr_div = reg_wr & hit_div;
	wire wr_gain = reg_wr & hit_gain;
	wire rd_div = reg_rd & hit_div;
	wire rd_gain = reg_rd & hit_gain;
	wire sel_m = reg_wdata[`FRD_SEL_BIT];
	wire [1:0] gain_sel = reg_wdata[`FRD_GAIN_SEL_HI:`FRD_GAIN_SEL_LO];
	wire wr_adc_gain = wr_gain & (gain_sel == `FRD_GAIN_SEL_ADC);
	wire wr_gain_other = wr_gain & (gain_sel != `FRD_GAIN_SEL_ADC);

	// ****************************************************************
	// Divider register writes
	// ****************************************************************
	// A write changes only the half that was addressed; the other half keeps its value.
	always_comb begin
		nxt_div_staged = div_staged_ff;
		nxt_divider_write_select = divider_write_select_ff;
		if (wr_div) begin
			nxt_divider_write_select = sel_m;
			if (sel_m) begin
				nxt_div_staged.m = reg_wdata[6:0];
			end else begin
				nxt_div_staged.n = reg_wdata[6:3];
				nxt_div_staged.p = reg_wdata[2:0];
			end
		end
	end

	// ****************************************************************
	// Divider decode
	// ****************************************************************
	// M zero is 128
	wire [7:0] m_factor = (div_active_ff.m == 7'h00) ? `FRD_M_ZERO_FACTOR :
		{1'b0, div_active_ff.m};
	wire [4:0] n_factor = (div_active_ff.n == 4'h0) ? `FRD_N_ZERO_FACTOR :
		{1'b0, div_active_ff.n};
	wire [3:0] p_factor = (div_active_ff.p == 3'h0) ? `FRD_P_ZERO_FACTOR :
		{1'b0, div_active_ff.p};

	wire [16:0] m_ext = {9'h000, m_factor};
	wire [16:0] n_ext = {12'h000, n_factor};
	wire [16:0] p_ext = {13'h0000, p_factor};
	wire [16:0] mnp_prod = m_ext * n_ext * p_ext;
	// The longest frame of 262144 clocks still fits the counter.
	// sixteen times M N P
	wire [20:0] frame_len = {4'h0, mnp_prod} << `FRD_FS_PRESCALE_SHIFT;
	wire fs_wrap = (fs_cnt_ff >= (frame_len - 21'h000001));

	// ****************************************************************
	// Frame sync generator
	// ****************************************************************
	// A shortened frame after an update wraps at once instead of
	// running through a stale longer count.
	always_comb begin
		nxt_fs_cnt = fs_cnt_ff + 21'h000001;
		nxt_frame_sync = 1'b0;
		if (fs_wrap) begin
			nxt_fs_cnt = 21'h000000;
			nxt_frame_sync = 1'b1;
		end
	end

	// ****************************************************************
	// Deferred apply of new divider values
	// ****************************************************************
	// A write during the wait restarts it, so the values come into force
	// at the second frame sync after the last write.
	always_comb begin
		nxt_apply_state = apply_state_ff;
		nxt_div_active = div_active_ff;
		unique case (apply_state_ff)
			FRD_APPLY_IDLE: begin
				if (wr_div) begin
					nxt_apply_state = FRD_APPLY_WAIT1;
				end
			end
			FRD_APPLY_WAIT1: begin
				if (wr_div) begin
					nxt_apply_state = FRD_APPLY_WAIT1;
				end else if (frame_sync_ff) begin
					nxt_apply_state = FRD_APPLY_WAIT2;
				end
			end
			FRD_APPLY_WAIT2: begin
				if (wr_div) begin
					nxt_apply_state = FRD_APPLY_WAIT1;
				end else if (frame_sync_ff) begin
					nxt_apply_state = FRD_APPLY_IDLE;
					nxt_div_active = div_staged_ff;
				end
			end
			default: begin
				nxt_apply_state = FRD_APPLY_IDLE;
			end
		endcase
	end

	// Coarse mode follows the values in force, not those just written.
	// coarse mode at P of 8
	assign nxt_coarse_mode = (nxt_div_active.p == 3'h0);

	// ****************************************************************
	// Fast bit clock
	// ****************************************************************
	// The counter runs free, so the tick phase does not hang on the mode
	// inputs; a smaller P in force wraps it at once.
	wire bclk_wrap = (bclk_cnt_ff >= (p_factor - 4'h1));
	always_comb begin
		nxt_bclk_cnt = bclk_wrap ? 4'h0 : (bclk_cnt_ff + 4'h1);
		nxt_bit_clock_tick = bclk_wrap & fast_bclk_en & serial_master;
	end

	// ****************************************************************
	// ADC gain register
	// ****************************************************************
	// The mute code still yields a dB figure one step above the top, so
	// users must test the mute flag before the gain value.
	always_comb begin
		nxt_adc_gain = adc_gain_ff;
		if (wr_adc_gain) begin
			nxt_adc_gain.code = reg_wdata[5:0];
			nxt_adc_gain.mute = (reg_wdata[5:0] == `FRD_ADC_MUTE_CODE);
			nxt_adc_gain.db = {1'b0, reg_wdata[5:0]} - `FRD_ZERO_DB_CODE;
		end
	end

	// Writes for the other subregisters are handed on unchanged.
	always_comb begin
		nxt_gain_sub_wr = wr_gain_other;
		nxt_gain_sub_wdata = wr_gain_other ? reg_wdata : gain_sub_wdata_ff;
	end

	// ****************************************************************
	// Read sequencing
	// ****************************************************************
	// N and P then M
	wire [7:0] div_rd_val = div_rd_ptr_ff ? {1'b1, div_staged_ff.m} :
		{1'b0, div_staged_ff.n, div_staged_ff.p};
	wire [7:0] adc_rd_val = {`FRD_GAIN_SEL_ADC, adc_gain_ff.code};
	wire [7:0] gain_rd_val = (gain_rd_ptr_ff == 2'h0) ? adc_rd_val :
		(gain_rd_ptr_ff == 2'h1) ? dac_gain_in :
		(gain_rd_ptr_ff == 2'h2) ? sidetone_in : sub4_in;

	// Reads of other offsets leave both pointers alone, so software can
	// resume a sequence after touching another register.
	always_comb begin
		nxt_div_rd_ptr = rd_div ? ~div_rd_ptr_ff : div_rd_ptr_ff;
		nxt_gain_rd_ptr = rd_gain ? (gain_rd_ptr_ff + 2'h1) : gain_rd_ptr_ff;
		// Read data stand for one cycle only; unmapped reads give zero.
		nxt_reg_rdata = 8'h00;
		if (rd_div) begin
			nxt_reg_rdata = div_rd_val;
		end else if (rd_gain) begin
			nxt_reg_rdata = gain_rd_val;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// divider defaults
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_staged_ff <= '{m: `FRD_M_RST, n: `FRD_N_RST, p: `FRD_P_RST};
			div_active_ff <= '{m: `FRD_M_RST, n: `FRD_N_RST, p: `FRD_P_RST};
			divider_write_select_ff <= `FRD_SEL_RST;
			apply_state_ff <= FRD_APPLY_IDLE;
			coarse_mode_ff <= 1'b1;
		end else begin
			div_staged_ff <= nxt_div_staged;
			div_active_ff <= nxt_div_active;
			divider_write_select_ff <= nxt_divider_write_select;
			apply_state_ff <= nxt_apply_state;
			coarse_mode_ff <= nxt_coarse_mode;
		end
	end

	// ****************************************************************
	// Frame and bit clock counters
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fs_cnt_ff <= 21'h000000;
			frame_sync_ff <= 1'b0;
			bclk_cnt_ff <= 4'h0;
			bit_clock_tick_ff <= 1'b0;
		end else begin
			fs_cnt_ff <= nxt_fs_cnt;
			frame_sync_ff <= nxt_frame_sync;
			bclk_cnt_ff <= nxt_bclk_cnt;
			bit_clock_tick_ff <= nxt_bit_clock_tick;
		end
	end

	// ****************************************************************
	// Gain registers
	// ****************************************************************
	// gain resets to 0 dB
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			adc_gain_ff <= '{code: `FRD_ADC_GAIN_RST, mute: 1'b0, db: 7'h00};
			gain_sub_wr_ff <= 1'b0;
			gain_sub_wdata_ff <= 8'h00;
		end else begin
			adc_gain_ff <= nxt_adc_gain;
			gain_sub_wr_ff <= nxt_gain_sub_wr;
			gain_sub_wdata_ff <= nxt_gain_sub_wdata;
		end
	end

	// ****************************************************************
	// Read path registers
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_rd_ptr_ff <= 1'b0;
			gain_rd_ptr_ff <= 2'h0;
			reg_rdata_ff <= 8'h00;
		end else begin
			div_rd_ptr_ff <= nxt_div_rd_ptr;
			gain_rd_ptr_ff <= nxt_gain_rd_ptr;
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata = reg_rdata_ff;
	assign frame_sync_rate = frame_sync_ff;
	assign bit_clock_tick = bit_clock_tick_ff;
	assign div_active = div_active_ff;
	assign divider_write_select = divider_write_select_ff;
	assign coarse_mode = coarse_mode_ff;
	assign adc_gain = adc_gain_ff;
	assign gain_sub_wr = gain_sub_wr_ff;
	assign gain_sub_wdata = gain_sub_wdata_ff;

endmodule : frd_regs

`default_nettype wire

//--- frd_host.sv
// Host processor model that drives the register port.
`timescale 1ns/1ps
`default_nettype none
module frd_host (
	// Clock
	input wire logic clk_sys,
	// Register port
	output var logic [3:0] reg_addr,
	output var logic [7:0] reg_wdata,
	output var logic reg_wr,
	output var logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Address, and after a write also the data, are inverted after each access so that a stale
	// value is never mistaken for a held one.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : frd_host
`default_nettype wire

//--- frd_regs_assertions.sv
// Port checks of the divider and gain register block.
`timescale 1ns/1ps
`default_nettype none
module frd_regs_assertions (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Observed outputs
	input wire logic frame_sync_rate,
	input wire logic coarse_mode,
	input wire logic divider_write_select,
	input wire frd_pkg::frd_div_type div_active,
	input wire frd_pkg::frd_adc_gain_type adc_gain,
	input wire logic gain_sub_wr,
	input wire logic [7:0] gain_sub_wdata
);
	import frd_pkg::*;
	wire logic div_wr = reg_wr && reg_addr == 4'h4;
	wire logic gain_wr = reg_wr && reg_addr == 4'h5;
	wire logic adc_wr = gain_wr && reg_wdata[7:6] == 2'h0;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_sel; div_wr |=> divider_write_select == $past(reg_wdata[7]);
	endproperty
	a_sel: assert property (p_sel) else $error("select bit wrong");
	property p_apply; $changed(div_active) |-> $past(frame_sync_rate);
	endproperty
	a_apply: assert property (p_apply) else $error("early apply");
	property p_coarse; coarse_mode == (div_active.p == 3'h0); endproperty
	a_coarse: assert property (p_coarse) else $error("coarse wrong");
	property p_adc; adc_wr |=> adc_gain.code == $past(reg_wdata[5:0]);
	endproperty
	a_adc: assert property (p_adc) else $error("adc code wrong");
	property p_sub; gain_wr && !adc_wr |=> gain_sub_wr &&
		gain_sub_wdata == $past(reg_wdata) && $stable(adc_gain.code);
	endproperty
	a_sub: assert property (p_sub) else $error("gain route wrong");
	property p_mute; adc_gain.mute == (adc_gain.code == 6'h3F); endproperty
	a_mute: assert property (p_mute) else $error("mute wrong");
	property p_db; !adc_gain.mute |->
		adc_gain.db == $signed({1'b0, adc_gain.code}) - 7'sh2A; endproperty
	a_db: assert property (p_db) else $error("gain step wrong");
	property p_rd; reg_rdata != 8'h00 |->
		$past(reg_rd) && $past(reg_addr[3:1]) == 3'h2; endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
endmodule : frd_regs_assertions
bind frd_regs frd_regs_assertions chk (.*);
`default_nettype wire

//--- frd_regs_tb.sv
// Self-checking bench of the divider and gain register block.
`timescale 1ns/1ps
`default_nettype none
module frd_regs_tb;
	import frd_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic fast_bclk_en = 1'b0;
	logic serial_master = 1'b0;
	wire logic [3:0] reg_addr;
	wire logic [7:0] reg_wdata;
	wire logic reg_wr;
	wire logic reg_rd;
	wire logic [7:0] reg_rdata;
	wire logic bit_clock_tick;
	wire logic frame_sync_rate;
	wire logic coarse_mode;
	wire logic divider_write_select;
	wire logic gain_sub_wr;
	wire logic [7:0] gain_sub_wdata;
	frd_div_type div_active;
	frd_adc_gain_type adc_gain;
	int err_count = 0;
	int n_tests = 0;
	logic [7:0] v;
	int n;

	initial forever #5 clk_sys = ~clk_sys;

	frd_host host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	frd_regs uut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .fast_bclk_en, .serial_master,
		.bit_clock_tick, .frame_sync_rate, .coarse_mode,
		.divider_write_select, .div_active, .adc_gain, .gain_sub_wr,
		.gain_sub_wdata, .dac_gain_in(8'h6A), .sidetone_in(8'hBC),
		.sub4_in(8'hD1));

	task automatic chk(input string nm, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Period in clocks between two pulses of the tick or the frame sync.
	task automatic gap(input bit b, input int lim, output int n);
		int k;
		int h;
		h = 0;
		n = 1;
		for (k = 0; k < lim && h < 2; k++) begin
			@(posedge clk_sys);
			#1;
			if ((b ? bit_clock_tick : frame_sync_rate) === 1'b1) h++;
			else if (h == 1) n++;
		end
		if (h < 2) begin
			err_count++;
			test_done();
		end
	endtask : gap

	// Wait for new divider values to come into force, counting frames.
	task automatic settle(input frd_div_type nd, output int p);
		int i;
		p = 0;
		for (i = 0; i < 30000 && div_active !== nd; i++) begin
			@(posedge clk_sys);
			#1;
			p += (frame_sync_rate !== 1'b0);
		end
		if (div_active !== nd) begin
			err_count++;
			test_done();
		end
	endtask : settle

	// Drive the mode inputs and count ticks over eight clocks.
	task automatic quiet(input logic en, input logic ms, output int p);
		int i;
		@(posedge clk_sys);
		fast_bclk_en <= en;
		serial_master <= ms;
		repeat (3) @(posedge clk_sys);
		p = 0;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			#1;
			p += (bit_clock_tick !== 1'b0);
		end
	endtask : quiet

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		#1;
		chk("div", div_active, {7'h10, 4'h6, 3'h0}); // defaults
		chk("coarse", coarse_mode, 1'b1); // at P of 8
		chk("sel", divider_write_select, 1'b0); // select
		chk("adc", adc_gain, {6'h2A, 1'b0, 7'h00}); // default
		host.rd(4'h4, v);
		chk("rd_np", v, 8'h30); // first read
		host.rd(4'h4, v);
		chk("rd_m", v, 8'h90); // second read
		host.rd(4'hF, v);
		chk("rd_none", v, 8'h00);
		gap(0, 30000, n);
		chk("frame0", n, 12288); // default period
		$display("reset test done");
	endtask : t_reset

	task automatic t_div;
		frd_div_type nd;
		int p;
		nd = {7'h01, 4'h1, 3'h2};
		host.wr(4'h4, 8'h81);
		chk("sel1", divider_write_select, 1'b1); // select
		host.wr(4'h4, 8'h0A);
		chk("sel0", divider_write_select, 1'b0); // select
		chk("held", div_active, {7'h10, 4'h6, 3'h0}); // deferred
		host.rd(4'h4, v);
		chk("np", v, 8'h0A); // staged N and P
		host.rd(4'h4, v);
		chk("m", v, 8'h81); // staged M
		settle(nd, p);
		chk("apply", div_active, nd); // new values
		chk("pulses", p, 2); // two frame syncs
		chk("coarse", coarse_mode, 1'b0); // normal mode
		gap(0, 200, n);
		chk("frame", n, 32); // new period
		$display("divider test done");
	endtask : t_div

	task automatic t_bclk;
		int p;
		@(posedge clk_sys);
		fast_bclk_en <= 1'b1;
		serial_master <= 1'b1;
		gap(1, 100, n);
		chk("bclk", n, 2); // clock over P
		quiet(1'b1, 1'b0, p);
		chk("bclk_off", p, 0); // slave mode
		quiet(1'b0, 1'b1, p);
		chk("bclk_slow", p, 0); // fast mode off
		$display("bit clock test done");
	endtask : t_bclk

	task automatic t_zero;
		int p;
		host.wr(4'h4, 8'h80);
		settle({7'h00, 4'h1, 3'h2}, p);
		gap(0, 9000, n);
		chk("m128", n, 4096); // M zero is 128
		host.wr(4'h4, 8'h81);
		host.wr(4'h4, 8'h01);
		settle({7'h01, 4'h0, 3'h1}, p);
		chk("pulses0", p, 2); // two frame syncs
		gap(0, 600, n);
		chk("n16", n, 256); // N zero is 16
		$display("zero field test done");
	endtask : t_zero

	task automatic t_gain;
		logic [7:0] e [5] = '{8'h3F, 8'h6A, 8'hBC, 8'hD1, 8'h3F};
		int i;
		host.wr(4'h5, 8'h3E);
		chk("g20", adc_gain, {6'h3E, 1'b0, 7'h14}); // top step
		host.wr(4'h5, 8'h00);
		chk("gmin", adc_gain, {6'h00, 1'b0, 7'h56}); // bottom step
		host.wr(4'h5, 8'h3F);
		chk("mute", adc_gain[13:7], 7'h7F); // muted
		host.wr(4'h5, 8'h45);
		chk("sub", {gain_sub_wr, gain_sub_wdata, adc_gain.code},
			{1'b1, 8'h45, 6'h3F}); // other subregister
		for (i = 0; i < 5; i++) begin
			host.rd(4'h5, v);
			chk("grd", v, e[i]); // read order
		end
		$display("gain test done");
	endtask : t_gain

	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_div();
		t_bclk();
		t_zero();
		t_gain();
		test_done();
	end
endmodule : frd_regs_tb
`default_nettype wire
